/* logic/spwm_pkg.sv */
/*
 Constants and carrier types shared by the PWM start, mode and
 output-enable control block. Assumes a 25 MHz timer operation clock and a
 classic Wishbone register port with 8-bit registers in the low byte lane.
*/
package spwm_pkg;
   localparam int ADDR_W = 12;
   localparam int IDX_W = 10;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_START = 10'h130;
   localparam logic [IDX_W-1:0] IDX_MODE = 10'h138;
   localparam logic [IDX_W-1:0] IDX_OUT_DIS = 10'h13b;
   localparam logic [IDX_W-1:0] IDX_CUTOFF = 10'h13c;
   localparam logic [IDX_W-1:0] IDX_FUNC = 10'h140;
   localparam logic [IDX_W-1:0] IDX_PIN_MODE = 10'h141;

   // Count start register fields
   localparam int START_CH0 = 0;
   localparam int START_CH1 = 1;
   localparam int STOP_SEL_CH0 = 2;
   localparam int STOP_SEL_CH1 = 3;
   // Mode register fields
   localparam int MODE_SYNC = 0;
   localparam int MODE_BUF_C0 = 4;
   localparam logic [7:0] MODE_RSV_MASK = 8'h0e;
   // Function control fields
   localparam int FUNC_CMD_LO = 0;
   localparam int FUNC_DUAL = 2;
   localparam logic [1:0] CMD_SINGLE = 2'h0;
   localparam logic [1:0] CMD_RSYNC = 2'h1;
   // Forced cutoff fields
   localparam int CUT_EN = 7;
   localparam logic [7:0] CUT_RSV_MASK = 8'h7f;

   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] OUT_DIS_RST = 8'hff;
   localparam logic [7:0] FUNC_RST = 8'h00;
   localparam logic [7:0] PIN_MODE_RST = 8'h00;
   localparam logic [7:0] ALL_DISABLED = 8'hff;

   typedef enum logic [1:0] {
      SPWM_MODE_SINGLE,
      SPWM_MODE_DUAL,
      SPWM_MODE_RSYNC,
      SPWM_MODE_COMPL
   } spwm_mode_e;

   typedef struct packed {
      logic wr;
      logic ok;
      logic [IDX_W-1:0] idx;
      logic [7:0] wdata;
   } spwm_req_s;
endpackage

/* logic/spwm_wb_slave.sv */
/*
 Classic Wishbone slave front end: answers every access with a one-cycle
 ack one cycle after the strobe, registers read data, and hands writes to
 the register file on the edge where the master samples ack.
 Assumes the master holds its request until it sees ack.
*/
`timescale 1ns/1ps
module spwm_wb_slave import spwm_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [7:0] rdata_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output spwm_req_s req_o
);
   logic active;

   assign active = cyc_i & stb_i;
   assign req_o.wr = active & we_i & ack_o & sel_i[0];
   assign req_o.ok = (adr_i[1:0] == 2'h0);
   assign req_o.idx = adr_i[ADDR_W-1:2];
   assign req_o.wdata = dat_i[7:0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= active & ~ack_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0;
      end else if (active & ~ack_o) begin
         dat_o <= {24'h0, rdata_i};
      end
   end

   chk_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      active && !ack_o |=> ack_o) else $error("ack missing after strobe");
   chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o) else $error("ack held longer than one cycle");
endmodule

/* logic/spwm_start_ctl.sv */
/*
 One channel's count start bit with its stop select bit. A compare match
 on the A register stops the channel when stop select is 0.
 Assumes the compare match input is a one-cycle pulse on the timer clock.
*/
`timescale 1ns/1ps
module spwm_start_ctl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic start_wdata_i,
   input wire logic stop_sel_wdata_i,
   input wire logic compare_a_i,
   output logic count_start_o,
   output logic stop_select_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_select_o <= 1'b0;
      end else if (wr_i) begin
         stop_select_o <= stop_sel_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_start_o <= 1'b0;
      end else if (wr_i) begin
         count_start_o <= start_wdata_i;
      end else if (compare_a_i && !stop_select_o) begin
         count_start_o <= 1'b0;
      end
   end

   chk_auto_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      compare_a_i && !stop_select_o && !wr_i |=> !count_start_o)
      else $error("start bit not cleared on compare match");
   chk_manual_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      count_start_o && stop_select_o && !wr_i |=> count_start_o)
      else $error("start bit cleared without a write");
   cov_auto_stop: cover property (@(posedge clk_i) disable iff (rst_i)
      count_start_o && compare_a_i && !stop_select_o ##1 !count_start_o);
endmodule

/* logic/spwm_ctrl.sv */
/*
 Start, mode and output-enable control of a two-channel 16-bit timer used
 in reset synchronous PWM mode, with the forced pulse cutoff.
 Assumes synchronous inputs on the timer clock, a classic Wishbone master
 and compare match pulses from the channel counters outside this block.
*/
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module spwm_ctrl import spwm_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ch0_compare_a_i,
   input wire logic ch1_compare_a_i,
   input wire logic ext_interrupt0_pin_n_i,
   input wire logic [7:0] waveform_i,
   input wire logic [7:0] port_data_i,
   output logic ch0_count_start_o,
   output logic ch1_count_start_o,
   output logic sync_o,
   output logic ch0_c_buffer_select_o,
   output spwm_mode_e mode_o,
   output logic fixed_period_dual_o,
   output logic [7:0] pin_pwm_mode_o,
   output logic [7:0] pin_drive_en_o,
   output logic [7:0] pin_o,
   output logic cutoff_active_o
);
   spwm_req_s req;
   logic [7:0] rdata;
   logic [7:0] mode_reg;
   logic [7:0] func_reg;
   logic [7:0] pin_mode_reg;
   logic [7:0] out_dis;
   logic [7:0] next_out_dis;
   logic forced_cutoff_enable;
   logic cutoff_hit;
   logic ch0_stop_select;
   logic ch1_stop_select;
   logic wr_start;
   logic wr_mode;
   logic wr_func;
   logic wr_pin_mode;
   logic wr_out_dis;
   logic wr_cutoff;
   logic combined;
   logic [1:0] combination_mode_field;
   logic rd_cycle;

   spwm_wb_slave u_bus (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc_i(wb_cyc_i),
      .stb_i(wb_stb_i),
      .we_i(wb_we_i),
      .adr_i(wb_adr_i),
      .sel_i(wb_sel_i),
      .dat_i(wb_dat_i),
      .rdata_i(rdata),
      .dat_o(wb_dat_o),
      .ack_o(wb_ack_o),
      .req_o(req)
   );

   assign wr_start = req.wr & req.ok & (req.idx == IDX_START);
   assign wr_mode = req.wr & req.ok & (req.idx == IDX_MODE);
   assign wr_func = req.wr & req.ok & (req.idx == IDX_FUNC);
   assign wr_pin_mode = req.wr & req.ok & (req.idx == IDX_PIN_MODE);
   assign wr_out_dis = req.wr & req.ok & (req.idx == IDX_OUT_DIS);
   assign wr_cutoff = req.wr & req.ok & (req.idx == IDX_CUTOFF);
   assign rd_cycle = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   spwm_start_ctl u_ch0 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_start),
      .start_wdata_i(req.wdata[START_CH0]),
      .stop_sel_wdata_i(req.wdata[STOP_SEL_CH0]),
      .compare_a_i(ch0_compare_a_i),
      .count_start_o(ch0_count_start_o),
      .stop_select_o(ch0_stop_select)
   );

   spwm_start_ctl u_ch1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_start),
      .start_wdata_i(req.wdata[START_CH1]),
      .stop_sel_wdata_i(req.wdata[STOP_SEL_CH1]),
      .compare_a_i(ch1_compare_a_i),
      .count_start_o(ch1_count_start_o),
      .stop_select_o(ch1_stop_select)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= MODE_RST;
      end else if (wr_mode) begin
         mode_reg <= req.wdata & ~MODE_RSV_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         func_reg <= FUNC_RST;
      end else if (wr_func) begin
         func_reg <= {5'h0, req.wdata[2:0]};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_mode_reg <= PIN_MODE_RST;
      end else if (wr_pin_mode) begin
         pin_mode_reg <= req.wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         forced_cutoff_enable <= 1'b0;
      end else if (wr_cutoff) begin
         forced_cutoff_enable <= req.wdata[CUT_EN];
      end
   end

   // low pin with enable cuts off
   assign cutoff_hit = forced_cutoff_enable & ~ext_interrupt0_pin_n_i;

   always_comb begin
      next_out_dis = out_dis;
      if (cutoff_hit) begin
         next_out_dis = ALL_DISABLED;
      end else if (wr_out_dis) begin
         next_out_dis = req.wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_dis <= OUT_DIS_RST;
      end else begin
         out_dis <= next_out_dis;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_drive_en_o <= 8'h00;
         pin_o <= 8'h00;
      end else begin
         pin_drive_en_o <= ~next_out_dis;
         for (int i = 0; i < 8; i++) begin
            pin_o[i] <= next_out_dis[i] ? port_data_i[i] : waveform_i[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cutoff_active_o <= 1'b0;
      end else begin
         cutoff_active_o <= cutoff_hit;
      end
   end

   assign combination_mode_field = func_reg[FUNC_CMD_LO +: 2];
   assign combined = (combination_mode_field != CMD_SINGLE);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_o <= SPWM_MODE_SINGLE;
         fixed_period_dual_o <= 1'b0;
         pin_pwm_mode_o <= 8'h00;
      end else begin
         if (!combined) begin
            mode_o <= func_reg[FUNC_DUAL] ? SPWM_MODE_DUAL : SPWM_MODE_SINGLE;
         end else if (combination_mode_field == CMD_RSYNC) begin
            mode_o <= SPWM_MODE_RSYNC;
         end else begin
            mode_o <= SPWM_MODE_COMPL;
         end
         fixed_period_dual_o <= !combined && func_reg[FUNC_DUAL];
         pin_pwm_mode_o <= combined ? 8'h00 : pin_mode_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ch0_c_buffer_select_o <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         ch0_c_buffer_select_o <= combined && mode_reg[MODE_BUF_C0];
         sync_o <= mode_reg[MODE_SYNC];
      end
   end

   always_comb begin
      rdata = 8'h00;
      if (req.ok) begin
         unique case (req.idx)
            IDX_START: begin
               rdata = {4'h0, ch1_stop_select, ch0_stop_select,
                        ch1_count_start_o, ch0_count_start_o};
            end
            IDX_MODE: begin
               rdata = mode_reg | MODE_RSV_MASK;
            end
            IDX_FUNC: begin
               rdata = func_reg;
            end
            IDX_PIN_MODE: begin
               rdata = pin_mode_reg;
            end
            IDX_OUT_DIS: begin
               rdata = out_dis;
            end
            IDX_CUTOFF: begin
               rdata = {forced_cutoff_enable, CUT_RSV_MASK[6:0]};
            end
            default: begin
               rdata = 8'h00;
            end
         endcase
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_cutoff_sets: assert property (
      cutoff_hit |=> out_dis == ALL_DISABLED && pin_drive_en_o == 8'h00)
      else $error("cutoff did not disable all pins");
   chk_cutoff_idle: assert property (
      !forced_cutoff_enable && !wr_out_dis |=> out_dis == $past(out_dis))
      else $error("disable bits changed with cutoff disabled");
   chk_cutoff_hold: assert property (
      out_dis == ALL_DISABLED && !wr_out_dis |=> out_dis == ALL_DISABLED)
      else $error("disable bits cleared without a write");
   chk_mode_rsv_read: assert property (
      rd_cycle && req.ok && req.idx == IDX_MODE
      |=> wb_ack_o && wb_dat_o[3:1] == 3'b111)
      else $error("mode reserved bits not read as one");
   chk_cutoff_rsv_read: assert property (
      rd_cycle && req.ok && req.idx == IDX_CUTOFF
      |=> wb_ack_o && wb_dat_o[6:0] == 7'h7f)
      else $error("cutoff reserved bits not read as one");
   chk_comb_ignore: assert property (
      combined |=> pin_pwm_mode_o == 8'h00 && mode_o != SPWM_MODE_SINGLE)
      else $error("per-pin modes not ignored in combined mode");
   chk_dual_gate: assert property (
      combined || !func_reg[FUNC_DUAL] |=> !fixed_period_dual_o)
      else $error("dual select acted outside single mode");
   chk_pin_source: assert property (
      next_out_dis[7:1] == 7'h00
      |=> pin_o[7:1] == $past(waveform_i[7:1]) && pin_drive_en_o[7:1] == 7'h7f)
      else $error("enabled pins do not carry the waveform");
   chk_buffer_sel: assert property (
      combined && mode_reg[MODE_BUF_C0] |=> ch0_c_buffer_select_o)
      else $error("C buffer select not applied");

   chk_dis_write: assert property (
      wr_out_dis && !cutoff_hit |=> out_dis == $past(req.wdata))
      else $error("disable bits did not take the written value");
   chk_port_source: assert property (
      next_out_dis == ALL_DISABLED
      |=> pin_o == $past(port_data_i) && pin_drive_en_o == 8'h00)
      else $error("disabled pins do not carry port data");
   chk_mode_rsv_store: assert property (
      wr_mode |=> mode_reg[3:1] == 3'b000)
      else $error("reserved mode bits were stored");
   chk_rsync_sel: assert property (
      combination_mode_field == CMD_RSYNC |=> mode_o == SPWM_MODE_RSYNC)
      else $error("reset synchronous mode not selected");
   chk_cut_flag: assert property (
      cutoff_hit |=> cutoff_active_o)
      else $error("cutoff flag not raised");
   chk_cut_clear: assert property (
      !cutoff_hit |=> !cutoff_active_o)
      else $error("cutoff flag raised without cause");

   cov_cutoff: cover property (forced_cutoff_enable && !ext_interrupt0_pin_n_i ##1 cutoff_active_o);
   cov_rsync: cover property (mode_o == SPWM_MODE_RSYNC && ch0_count_start_o);
   cov_rewrite: cover property (out_dis == ALL_DISABLED ##1 wr_out_dis ##1 out_dis != ALL_DISABLED);
   cov_dual: cover property (fixed_period_dual_o && mode_o == SPWM_MODE_DUAL);
endmodule

/* sim/spwm_gate_model.sv */
/*
 Stand-in for the motor power stage: its fault line pulls the cutoff
 input low while the bench commands a fault.
 Assumes the fault line has a pull-up and is read on the timer clock.
*/
`timescale 1ns/1ps
module spwm_gate_model (
   input wire logic clk_i,
   input wire logic fault_cmd_i,
   output logic fault_n_o
);
   // Line sits at the pull-up level unless the stage reports a fault
   always_ff @(posedge clk_i) begin
      fault_n_o <= ~fault_cmd_i;
   end
endmodule

/* sim/spwm_ctrl_tb_top.sv */
/*
 Self-checking bench for the PWM start, mode and output-enable control.
 Assumes the design answers each Wishbone access with a single ack.
*/
`timescale 1ns/1ps
module spwm_ctrl_tb_top import spwm_pkg::*; ;
   logic clk, rst, cyc, stb, we, cmp0, cmp1, fault_cmd, fault_n;
   logic ack, start0, start1, sync, buf_c0, dual, cut;
   logic [ADDR_W-1:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, r;
   logic [7:0] wave, port, pwm_mode, drive_en, pins, d;
   spwm_mode_e mode, em;
   int err_count, tests_run;
   integer seed;
   logic [31:0] exp_q[$];

   spwm_ctrl u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .ch0_compare_a_i(cmp0), .ch1_compare_a_i(cmp1),
      .ext_interrupt0_pin_n_i(fault_n), .waveform_i(wave), .port_data_i(port),
      .ch0_count_start_o(start0), .ch1_count_start_o(start1), .sync_o(sync),
      .ch0_c_buffer_select_o(buf_c0), .mode_o(mode), .fixed_period_dual_o(dual),
      .pin_pwm_mode_o(pwm_mode), .pin_drive_en_o(drive_en), .pin_o(pins),
      .cutoff_active_o(cut));

   spwm_gate_model u_gate (.clk_i(clk), .fault_cmd_i(fault_cmd), .fault_n_o(fault_n));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test();
      if (exp_q.size() != 0) begin
         err_count++;
      end
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Read data is matched against the oldest note
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0) begin
         if (exp_q.size() == 0) begin
            cmp_val("spare read", 32'h0, 32'hffffffff);
         end else begin
            cmp_val("read data", exp_q.pop_front(), rdat);
         end
      end
   end

   task automatic bus(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] v);
      int n;
      @(posedge clk);
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h0, v};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         err_count++;
         $display("BAD bus ack expected 1 seen %b", ack);
         finish_test();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] v);
      bus(1'b1, idx, v);
   endtask

   task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] v);
      exp_q.push_back({24'h0, v});
      bus(1'b0, idx, 8'h00);
   endtask

   task automatic pulse(input logic [1:0] m);
      @(posedge clk);
      cmp0 <= m[0];
      cmp1 <= m[1];
      @(posedge clk);
      cmp0 <= 1'b0;
      cmp1 <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask

   initial begin
      seed = 32'h2975;
      err_count = 0;
      tests_run = 0;
      rst = 1'b1;
      {cyc, stb, we, cmp0, cmp1, fault_cmd} = 6'h00;
      adr = '0;
      sel = 4'h1;
      wdat = 32'h0;
      wave = 8'h00;
      port = 8'h00;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      cmp_val("drive en", 8'h00, drive_en);
      rd(IDX_START, 8'h00);
      rd(IDX_MODE, 8'h0e);
      rd(IDX_OUT_DIS, 8'hff);
      rd(IDX_CUTOFF, 8'h7f);
      rd(IDX_FUNC, 8'h00);
      rd(IDX_PIN_MODE, 8'h00);
      rd(10'h3ff, 8'h00);
      wr(IDX_MODE, 8'hf0);
      rd(IDX_MODE, 8'hfe);
      wr(IDX_CUTOFF, 8'h00);
      rd(IDX_CUTOFF, 8'h7f);
      wr(IDX_MODE, 8'h10);
      wr(IDX_PIN_MODE, 8'hff);
      // Every combination field value, with and without dual select
      for (int c = 0; c < 8; c++) begin
         wr(IDX_FUNC, 8'(c));
         @(negedge clk);
         em = (c[1:0] == 2'h0) ? (c[2] ? SPWM_MODE_DUAL : SPWM_MODE_SINGLE) :
              ((c[1:0] == 2'h1) ? SPWM_MODE_RSYNC : SPWM_MODE_COMPL);
         cmp_val("mode", em, mode);
         cmp_val("dual", c[2] && c[1:0] == 2'h0, dual);
         cmp_val("pin mode", (c[1:0] == 2'h0) ? 8'hff : 8'h00, pwm_mode);
         cmp_val("c buffer", c[1:0] != 2'h0, buf_c0);
      end
      wr(IDX_FUNC, 8'h01);
      wr(IDX_START, 8'h03);
      pulse(2'b01);
      cmp_val("ch0 start", 1'b0, start0);
      cmp_val("ch1 start", 1'b1, start1);
      pulse(2'b10);
      cmp_val("ch1 start", 1'b0, start1);
      wr(IDX_START, 8'h0f);
      pulse(2'b11);
      cmp_val("held starts", 2'b11, {start1, start0});
      rd(IDX_START, 8'h0f);
      wr(IDX_START, 8'h0c);
      @(negedge clk);
      cmp_val("sw stop", 2'b00, {start1, start0});
      cmp_val("sync", 1'b0, sync);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         r = $random(seed);
         wave <= r[7:0];
         port <= r[15:8];
         d = r[23:16] | 8'h01;
         wr(IDX_OUT_DIS, d);
         @(negedge clk);
         cmp_val("drive en", 8'(~d), drive_en);
         cmp_val("pins", 8'((wave & ~d) | (port & d)), pins);
         rd(IDX_OUT_DIS, d);
      end
      wr(IDX_OUT_DIS, 8'h01);
      @(posedge clk);
      fault_cmd <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      cmp_val("no cutoff", 8'hfe, drive_en);
      @(posedge clk);
      fault_cmd <= 1'b0;
      wr(IDX_CUTOFF, 8'h80);
      rd(IDX_CUTOFF, 8'hff);
      @(posedge clk);
      fault_cmd <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      cmp_val("cut drive", 8'h00, drive_en);
      cmp_val("cut pins", port, pins);
      cmp_val("cut flag", 1'b1, cut);
      @(posedge clk);
      fault_cmd <= 1'b0;
      repeat (4) @(posedge clk);
      rd(IDX_OUT_DIS, 8'hff);
      wr(IDX_OUT_DIS, 8'h01);
      @(negedge clk);
      cmp_val("rewrite", 8'hfe, drive_en);
      cmp_val("cut flag", 1'b0, cut);
      repeat (2) @(posedge clk);
      finish_test();
   end
endmodule
